// [pkg/smfs_consts.vh]
// What this block does
// - Electrical fault is OR of charge pump, undervoltage, coil defect, supply reset.
// - After reset enter shutdown; leave only after a full status read.
// - Two-phase positioning uses own parameters copied at start from dual values, or from working values if those are 0.
// - Acceleration shape forced to 1 in second motion; restored value applies after.
// - Full status read reports working velocity values, not sequence copies.
// - Shutdown left only with thermal and electrical fault flags clear.
// - Fault flags clear only on full status read with conditions normal.
// - Secure enable is 1 when secure position differs from 0x400.
// - Stop flag set leaving a halt state, cleared first cycle in stopped.
// - Stopped with position mismatch goes to moving, lowest priority.
// - Step loss blocks set target and go secure; only status read clears it.
// - Frequency select bit 6 of byte 7: 0 gives 22.8 kHz, 1 gives 45.6 kHz.
// - Jitter enable bit 0 of byte 7 adds PWM jitter; readable in status.
// - Motion start switches hold current straight to run current at first step.
// - After deceleration run level for stabilization time, then standstill current.
// - Charge pump low forces abrupt halt and sets charge pump failure flag.
// - Charge pump failure during motion also sets step loss.
// - Long 100 percent duty flags open coil; bridge drop opens bridge, flags defect.
// - Any shutdown cause: bridges high impedance, target loaded from actual.
// - Command interface stays operational during shutdown.
// - Shutdown ends on status read with causes gone; bridges apply hold current.
`ifndef SMFS_CONSTS_VH
`define SMFS_CONSTS_VH
// Register offsets
`define SMFS_A_CMD      4'h0
`define SMFS_A_TARGET   4'h1
`define SMFS_A_SECURE_POSITION_VALUE   4'h2
`define SMFS_A_MPARAM   4'h3
`define SMFS_A_DUAL     4'h4
`define SMFS_A_STATUS   4'h5
`define SMFS_A_ACTUAL   4'h6
`define SMFS_A_VEL      4'h7
// Command codes in the command register
`define SMFS_C_STATUS   8'h01
`define SMFS_C_SETTGT   8'h02
`define SMFS_C_GOSEC    8'h03
`define SMFS_C_ZERO     8'h04
`define SMFS_C_DUAL     8'h05
`define SMFS_C_HARD     8'h06
`define SMFS_C_SOFT     8'h07
`define SMFS_C_DEFAULT  8'h08
`define SMFS_C_STALLP   8'h09
// Parameter byte fields
`define SMFS_B_FREQ     6
`define SMFS_B_JIT      0
`define SMFS_B_SHAPE    7
`define SMFS_VMAX_HI    11
`define SMFS_VMAX_LO    8
`define SMFS_VMIN_HI    15
`define SMFS_VMIN_LO    12
`define SMFS_SEC_OFF    11'h400
`define SMFS_POS_W      16
// Defaults restored
`define SMFS_DEF_MPARAM 16'h5200
// Timing
`define SMFS_CLK_NS       10
`define SMFS_STAB_NS      1000
`define SMFS_STAB_CYC     ((`SMFS_STAB_NS + `SMFS_CLK_NS - 1) / `SMFS_CLK_NS)
`define SMFS_OPEN_CYC_DEF 100000
`define SMFS_CNT_W        20
`define SMFS_ZERO_CNT     20'h00000
`define SMFS_ONE_CNT      20'h00001
// States
`define SMFS_S_STOP  3'h0
`define SMFS_S_MOVE  3'h1
`define SMFS_S_DUAL  3'h2
`define SMFS_S_HARD  3'h3
`define SMFS_S_SOFT  3'h4
`define SMFS_S_STAB  3'h5
`define SMFS_S_SHUT  3'h6
`endif

// [rtl/smfs_supervisor.v]
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "smfs_consts.vh"
module smfs_supervisor #(
  parameter OPEN_CYC = `SMFS_OPEN_CYC_DEF
) (
  input  wire        sys_clk_i,
  input  wire        reset_i,
  input  wire [3:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  input  wire        tsd_i,
  input  wire        uv2_i,
  input  wire        cp_low_i,
  input  wire        bridge_drop_i,
  input  wire        duty_full_i,
  input  wire        decel_done_i,
  input  wire        step_done_i,
  output reg         bridge_hiz_o,
  output reg         run_current_o,
  output reg         pwm_freq_sel_o,
  output reg         pwm_jitter_o,
  output reg         accel_shape_o,
  output reg         sec_en_o,
  output reg  [2:0]  state_o
);
  // ==========================================================
  // Registers
  reg [2:0]  state_q;
  reg [15:0] target_q, actual_q, mparam_q, dual_q, dualpar_q;
  reg [10:0] secure_position_value_q;
  reg        stop_q, steploss_q, cpfail_q, eldef_q, uv2_q, vdd_q, tsd_q;
  reg        phase2_q, oneshot_q;
  reg [`SMFS_CNT_W-1:0] stab_q, open_q;

  wire wr_cmd  = wr_i && (addr_i == `SMFS_A_CMD);
  wire [7:0] cmd = wdata_i[7:0];
  wire c_stat  = wr_cmd && (cmd == `SMFS_C_STATUS);
  wire c_tgt   = wr_i && (addr_i == `SMFS_A_TARGET);
  wire c_sec   = wr_cmd && (cmd == `SMFS_C_GOSEC);
  wire c_zero  = wr_cmd && (cmd == `SMFS_C_ZERO);
  wire c_dual  = wr_cmd && (cmd == `SMFS_C_DUAL);
  wire c_hard  = wr_cmd && (cmd == `SMFS_C_HARD);
  wire c_soft  = wr_cmd && (cmd == `SMFS_C_SOFT);
  wire c_def   = wr_cmd && (cmd == `SMFS_C_DEFAULT);
  wire c_stall = wr_cmd && (cmd == `SMFS_C_STALLP);
  wire sec_en  = (secure_position_value_q != `SMFS_SEC_OFF);
  wire [15:0] sec_ext = {{5{secure_position_value_q[10]}}, secure_position_value_q};
  wire elflag  = cpfail_q | uv2_q | eldef_q | vdd_q;
  wire cause   = tsd_i | uv2_i | cp_low_i | bridge_drop_i | (open_q == OPEN_CYC);
  wire moving  = (state_q == `SMFS_S_MOVE) || (state_q == `SMFS_S_DUAL);
  wire clr_ok  = c_stat && !cause;

  // ==========================================================
  // Fault flags: set beats clear
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cpfail_q   <= 1'b0;
      eldef_q    <= 1'b0;
      uv2_q      <= 1'b0;
      tsd_q      <= 1'b0;
      vdd_q      <= 1'b1;
      steploss_q <= 1'b0;
      open_q     <= `SMFS_ZERO_CNT;
    end
    else
    begin
      // Open coil: saturated duty held long
      if (!duty_full_i)
        open_q <= `SMFS_ZERO_CNT;
      else if (open_q != OPEN_CYC)
        open_q <= open_q + `SMFS_ONE_CNT;
      cpfail_q <= cp_low_i | (cpfail_q & ~clr_ok);
      eldef_q  <= bridge_drop_i | (open_q == OPEN_CYC) | (eldef_q & ~clr_ok);
      uv2_q    <= uv2_i | (uv2_q & ~clr_ok);
      tsd_q    <= tsd_i | (tsd_q & ~clr_ok);
      vdd_q    <= vdd_q & ~clr_ok;
      // Step loss cleared only by status read
      steploss_q <= (cp_low_i & moving) | (c_hard & moving) | (steploss_q & ~c_stat);
    end
  end

  // ==========================================================
  // Motion state machine
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q   <= `SMFS_S_SHUT;
      target_q  <= 16'h0000;
      actual_q  <= 16'h0000;
      stop_q    <= 1'b0;
      phase2_q  <= 1'b0;
      oneshot_q <= 1'b0;
      stab_q    <= `SMFS_ZERO_CNT;
      dualpar_q <= 16'h0000;
    end
    else
    begin
      // Actual position follows completed steps
      if (c_zero && (state_q == `SMFS_S_STOP || state_q == `SMFS_S_SHUT))
      begin
        actual_q <= 16'h0000;
        target_q <= 16'h0000;
      end
      // A step reported at the target must not walk the position back
      else if (step_done_i && moving && (actual_q != target_q))
        actual_q <= (target_q > actual_q) ? actual_q + 16'h0001 : actual_q - 16'h0001;
      // Target updates are blocked while step loss stands
      if (!steploss_q && (state_q == `SMFS_S_STOP || moving))
      begin
        if (c_tgt)
          target_q <= wdata_i;
        else if (c_sec && sec_en)
          target_q <= sec_ext;
      end
      case (state_q)
        `SMFS_S_STOP:
        begin
          stop_q <= 1'b0;
          if (tsd_q || elflag || cp_low_i)
          begin
            state_q  <= `SMFS_S_SHUT;
            target_q <= actual_q;
          end
          else if (c_dual)
          begin
            dualpar_q <= (dual_q == 16'h0000) ? mparam_q : dual_q;
            phase2_q  <= 1'b0;
            state_q   <= `SMFS_S_DUAL;
          end
          else if (actual_q != target_q)
            state_q <= `SMFS_S_MOVE;
        end
        `SMFS_S_MOVE, `SMFS_S_DUAL:
        begin
          if (c_hard || cp_low_i || uv2_i || bridge_drop_i)
            state_q <= `SMFS_S_HARD;
          else if (c_soft || tsd_i)
            state_q <= `SMFS_S_SOFT;
          else if (state_q == `SMFS_S_DUAL && decel_done_i && !phase2_q)
            phase2_q <= 1'b1;
          else if (decel_done_i || (state_q == `SMFS_S_MOVE && actual_q == target_q))
          begin
            phase2_q <= 1'b0;
            stab_q   <= `SMFS_ZERO_CNT;
            state_q  <= `SMFS_S_STAB;
          end
        end
        `SMFS_S_HARD, `SMFS_S_SOFT:
        begin
          stop_q   <= 1'b1;
          target_q <= actual_q;
          state_q  <= `SMFS_S_STOP;
        end
        `SMFS_S_STAB:
        begin
          // No new positioning until the hold level is reached
          if (stab_q == `SMFS_STAB_CYC - 1)
            state_q <= `SMFS_S_STOP;
          else
            stab_q <= stab_q + `SMFS_ONE_CNT;
        end
        default:
        begin
          // Commands still served here; only exit needs clean status
          target_q <= actual_q;
          if (c_stat && !cause && !tsd_i && !(cpfail_q & cp_low_i))
            state_q <= `SMFS_S_STOP;
        end
      endcase
      oneshot_q <= c_stat;
    end
  end

  // ==========================================================
  // Software registers
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      secure_position_value_q <= `SMFS_SEC_OFF;
      mparam_q <= `SMFS_DEF_MPARAM;
      dual_q   <= 16'h0000;
    end
    else
    begin
      if (wr_i && addr_i == `SMFS_A_SECURE_POSITION_VALUE)
        secure_position_value_q <= wdata_i[10:0];
      if (wr_i && addr_i == `SMFS_A_MPARAM)
        mparam_q <= wdata_i;
      else if (c_stall)
        mparam_q[`SMFS_B_JIT] <= wdata_i[8 + `SMFS_B_JIT];
      else if (c_def)
        mparam_q <= `SMFS_DEF_MPARAM;
      if (wr_i && addr_i == `SMFS_A_DUAL)
        dual_q <= wdata_i;
    end
  end

  // ==========================================================
  // Read data, one cycle later
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_o <= 16'h0000;
    else if (!rd_i)
      rdata_o <= 16'h0000;
    else if (addr_i == `SMFS_A_STATUS)
      rdata_o <= {4'h0, mparam_q[`SMFS_B_JIT], stop_q, steploss_q, sec_en,
                  tsd_q, elflag, vdd_q, cpfail_q, uv2_q, eldef_q, state_q[1:0]};
    else if (addr_i == `SMFS_A_TARGET)
      rdata_o <= target_q;
    else if (addr_i == `SMFS_A_ACTUAL)
      rdata_o <= actual_q;
    else if (addr_i == `SMFS_A_SECURE_POSITION_VALUE)
      rdata_o <= {5'h00, secure_position_value_q};
    else if (addr_i == `SMFS_A_MPARAM)
      rdata_o <= mparam_q;
    else if (addr_i == `SMFS_A_VEL)
      rdata_o <= {8'h00, mparam_q[`SMFS_VMIN_HI:`SMFS_VMIN_LO],
                  mparam_q[`SMFS_VMAX_HI:`SMFS_VMAX_LO]};
    else if (addr_i == `SMFS_A_DUAL)
      rdata_o <= dual_q;
    else
      rdata_o <= 16'h0000;
  end

  // ==========================================================
  // Drive outputs
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bridge_hiz_o   <= 1'b1;
      run_current_o  <= 1'b0;
      pwm_freq_sel_o <= 1'b0;
      pwm_jitter_o   <= 1'b0;
      accel_shape_o  <= 1'b0;
      sec_en_o       <= 1'b0;
      state_o        <= `SMFS_S_SHUT;
    end
    else
    begin
      bridge_hiz_o   <= (state_q == `SMFS_S_SHUT);
      // Run level kept through stabilization, hold level only after it
      run_current_o  <= moving || (state_q == `SMFS_S_STAB);
      pwm_freq_sel_o <= mparam_q[`SMFS_B_FREQ];
      pwm_jitter_o   <= mparam_q[`SMFS_B_JIT];
      accel_shape_o  <= (state_q == `SMFS_S_DUAL) ?
                        (phase2_q | dualpar_q[`SMFS_B_SHAPE]) : mparam_q[`SMFS_B_SHAPE];
      sec_en_o       <= sec_en;
      state_o        <= state_q;
    end
  end
endmodule // smfs_supervisor
`default_nettype wire

// [verif/smfs_checker.sv]
`timescale 1ns/100ps
`default_nettype none
`include "smfs_consts.vh"
module smfs_checker (
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        tsd_i,
  input wire logic        uv2_i,
  input wire logic        cp_low_i,
  input wire logic        bridge_drop_i,
  input wire logic        decel_done_i,
  input wire logic        bridge_hiz_o,
  input wire logic        run_current_o,
  input wire logic        pwm_freq_sel_o,
  input wire logic        pwm_jitter_o,
  input wire logic        sec_en_o
);
  // ==========================================
  // Decoded requests and fault causes
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  wire logic st_cmd = wr_i && addr_i == `SMFS_A_CMD && wdata_i[7:0] == `SMFS_C_STATUS;
  wire logic mp_wr  = wr_i && addr_i == `SMFS_A_MPARAM;
  wire logic sp_wr  = wr_i && addr_i == `SMFS_A_SECURE_POSITION_VALUE;
  wire logic cause  = tsd_i || uv2_i || cp_low_i || bridge_drop_i;
  // ==========================================
  // Shutdown entry and exit
  chk_exit_on_status: assert property ($fell(bridge_hiz_o) |-> $past(st_cmd, 2))
    else $error("shutdown left without status read");
  chk_exit_when_clean: assert property ($fell(bridge_hiz_o) |-> !$past(cause, 2))
    else $error("shutdown left while a cause persists");
  chk_fault_enters: assert property ((uv2_i || bridge_drop_i) [*2] |-> ##[0:4] bridge_hiz_o)
    else $error("fault did not reach shutdown");
  chk_no_current_off: assert property (bridge_hiz_o && $past(bridge_hiz_o) |-> !run_current_o)
    else $error("run current while bridges off");
  // Current kept for the first 8 cycles after deceleration ends, no early drop
  chk_stab_hold: assert property (decel_done_i && run_current_o && !cause |=> run_current_o [*8])
    else $error("current dropped before stabilization");
  // ==========================================
  // Parameter outputs follow their written bits
  chk_sec_enable: assert property (sp_wr |-> ##2 sec_en_o == ($past(wdata_i[10:0], 2) != `SMFS_SEC_OFF))
    else $error("secure enable wrong");
  chk_freq_sel: assert property (mp_wr |-> ##2 pwm_freq_sel_o == $past(wdata_i[`SMFS_B_FREQ], 2))
    else $error("frequency select wrong");
  chk_jitter_sel: assert property (mp_wr |-> ##2 pwm_jitter_o == $past(wdata_i[`SMFS_B_JIT], 2))
    else $error("jitter enable wrong");
endmodule // smfs_checker
bind smfs_supervisor smfs_checker chk_u (.sys_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .tsd_i, .uv2_i,
  .cp_low_i, .bridge_drop_i, .decel_done_i, .bridge_hiz_o, .run_current_o, .pwm_freq_sel_o,
  .pwm_jitter_o, .sec_en_o);
`default_nettype wire

// [verif/smfs_master.sv]
`timescale 1ns/100ps
`default_nettype none
`include "smfs_consts.vh"
module smfs_master (
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] rdata_i,
  output var  logic [3:0]  addr_o,
  output var  logic [15:0] wdata_o,
  output var  logic        wr_o,
  output var  logic        rd_o
);
  // ==========================================
  // Idle bus at time zero
  initial
  begin
    addr_o  = 4'h0;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // One-cycle write; released data inverted so stale values never match
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge sys_clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge sys_clk_i);
    rd_o   <= 1'b0;
    @(posedge sys_clk_i);
    d = rdata_i;
  endtask
  // One recovery attempt per call, never a blind retry loop
  task automatic status_read;
    wr(`SMFS_A_CMD, {8'h00, `SMFS_C_STATUS});
    repeat (3) @(posedge sys_clk_i);
  endtask
endmodule // smfs_master
`default_nettype wire

// [verif/tb_stepper_motion_fault_supervisor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "smfs_consts.vh"
module tb_stepper_motion_fault_supervisor;
  logic        sys_clk_i    = 1'b0;
  logic        reset_i      = 1'b1;
  logic [4:0]  flt          = 5'h00;
  logic        decel_done_i = 1'b0;
  logic        step_done_i  = 1'b0;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, v, w;
  logic        wr_i, rd_i, bridge_hiz_o, run_current_o, pwm_freq_sel_o, pwm_jitter_o, accel_shape_o, sec_en_o;
  logic [2:0]  state_o;
  int          err_count = 0;
  int          cmp_count = 0;
  int          i;
  // ==========================================
  // Clock, partner and design
  always #5 sys_clk_i = ~sys_clk_i;
  smfs_master m_u (.sys_clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  smfs_supervisor #(.OPEN_CYC(20)) dut_u (.sys_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .uv2_i(flt[0]), .cp_low_i(flt[1]), .bridge_drop_i(flt[2]), .duty_full_i(flt[3]), .tsd_i(flt[4]),
    .decel_done_i, .step_done_i, .bridge_hiz_o, .run_current_o, .pwm_freq_sel_o, .pwm_jitter_o,
    .accel_shape_o, .sec_en_o, .state_o);
  // ==========================================
  // Compare and verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d of %0d compares", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    chk(state_o, `SMFS_S_SHUT);
    m_u.rd(`SMFS_A_STATUS, v);
    chk(v[5], 1'b1);
    chk(v[6], 1'b1);
    chk(v[8], 1'b0);
    chk(bridge_hiz_o, 1'b1);
    m_u.status_read;
    chk(bridge_hiz_o, 1'b0);
    chk(run_current_o, 1'b0);
  endtask
  // Parameter writes while stopped, then stall and default commands
  task automatic t_param;
    m_u.wr(`SMFS_A_SECURE_POSITION_VALUE, 16'h03FF);
    m_u.wr(`SMFS_A_MPARAM, 16'h52C1);
    m_u.rd(`SMFS_A_STATUS, v);
    chk({sec_en_o, pwm_freq_sel_o, pwm_jitter_o, accel_shape_o}, 4'hF);
    chk(v[11], 1'b1);
    m_u.wr(`SMFS_A_SECURE_POSITION_VALUE, 16'h0400);
    m_u.wr(`SMFS_A_MPARAM, 16'h5200);
    repeat (3) @(posedge sys_clk_i);
    chk({sec_en_o, pwm_freq_sel_o, pwm_jitter_o}, 3'h0);
    m_u.wr(`SMFS_A_CMD, 16'h0109);
    repeat (3) @(posedge sys_clk_i);
    chk(pwm_jitter_o, 1'b1);
    m_u.wr(`SMFS_A_CMD, 16'h0008);
    repeat (3) @(posedge sys_clk_i);
    chk({pwm_jitter_o, accel_shape_o}, 2'h0);
  endtask
  // Fault k held, one attempt refused, cleared, recovered
  task automatic t_fault(input int k, input int b);
    @(posedge sys_clk_i);
    flt[k] <= 1'b1;
    repeat (30) @(posedge sys_clk_i);
    chk(bridge_hiz_o, 1'b1);
    m_u.status_read;
    chk(bridge_hiz_o, 1'b1);
    m_u.rd(`SMFS_A_STATUS, v);
    chk(v[b], 1'b1);
    chk(v[6], k != 4);
    flt[k] <= 1'b0;
    m_u.status_read;
    chk(bridge_hiz_o, 1'b0);
    chk(state_o, `SMFS_S_STOP);
  endtask
  task automatic t_move;
    m_u.rd(`SMFS_A_ACTUAL, w);
    m_u.wr(`SMFS_A_TARGET, w + 16'h0004);
    repeat (3) @(posedge sys_clk_i);
    chk(state_o, `SMFS_S_MOVE);
    chk(run_current_o, 1'b1);
    // Four steps reach the target; deceleration ends with the last one
    for (i = 0; i < 4; i++)
    begin
      step_done_i  <= 1'b1;
      decel_done_i <= (i == 3);
      @(posedge sys_clk_i);
      step_done_i  <= 1'b0;
      decel_done_i <= 1'b0;
      @(posedge sys_clk_i);
    end
    for (i = 0; i < 300 && state_o !== `SMFS_S_STOP; i++) @(posedge sys_clk_i);
    chk(i >= 99, 1'b1);
    chk(i <= 102, 1'b1);
    chk(run_current_o, 1'b0);
    m_u.rd(`SMFS_A_ACTUAL, v);
    chk(v, w + 16'h0004);
  endtask
  // Two-phase sequence: shape forced in phase two, defaults deferred
  task automatic t_dual;
    m_u.wr(`SMFS_A_DUAL, 16'h0000);
    m_u.wr(`SMFS_A_CMD, 16'h0005);
    repeat (3) @(posedge sys_clk_i);
    chk({run_current_o, accel_shape_o}, 2'h2);
    decel_done_i <= 1'b1;
    @(posedge sys_clk_i);
    decel_done_i <= 1'b0;
    m_u.wr(`SMFS_A_CMD, 16'h0008);
    repeat (3) @(posedge sys_clk_i);
    chk(accel_shape_o, 1'b1);
    m_u.rd(`SMFS_A_VEL, v);
    chk(v, 16'h0052);
    decel_done_i <= 1'b1;
    @(posedge sys_clk_i);
    decel_done_i <= 1'b0;
    for (i = 0; i < 300 && state_o !== `SMFS_S_STOP; i++) @(posedge sys_clk_i);
    chk(state_o, `SMFS_S_STOP);
    chk(accel_shape_o, 1'b0);
  endtask
  // Commanded halt in motion: step loss blocks new targets until status read
  task automatic t_halt;
    m_u.rd(`SMFS_A_ACTUAL, w);
    m_u.wr(`SMFS_A_TARGET, w + 16'h0008);
    repeat (3) @(posedge sys_clk_i);
    m_u.wr(`SMFS_A_CMD, 16'h0006);
    repeat (3) @(posedge sys_clk_i);
    chk(state_o, `SMFS_S_STOP);
    m_u.rd(`SMFS_A_STATUS, v);
    chk(v[9], 1'b1);
    m_u.wr(`SMFS_A_TARGET, w + 16'h0020);
    m_u.rd(`SMFS_A_TARGET, v);
    chk(v, w);
    m_u.status_read;
    m_u.rd(`SMFS_A_STATUS, v);
    chk(v[9], 1'b0);
  endtask
  task automatic t_cp;
    m_u.rd(`SMFS_A_ACTUAL, w);
    m_u.wr(`SMFS_A_TARGET, w + 16'h0010);
    repeat (3) @(posedge sys_clk_i);
    flt[1] <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    m_u.rd(`SMFS_A_STATUS, v);
    chk({v[4], v[9], bridge_hiz_o}, 3'h7);
    m_u.rd(`SMFS_A_ACTUAL, w);
    m_u.wr(`SMFS_A_TARGET, w + 16'h0033);
    m_u.rd(`SMFS_A_TARGET, v);
    chk(v, w);
    flt[1] <= 1'b0;
    m_u.status_read;
    m_u.rd(`SMFS_A_STATUS, v);
    chk({v[9], bridge_hiz_o}, 2'h0);
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    i = 0;
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    t_reset;
    t_param;
    t_fault(0, 3);
    t_fault(1, 4);
    t_fault(2, 2);
    t_fault(3, 2);
    t_fault(4, 7);
    t_move;
    t_dual;
    t_halt;
    t_cp;
    summarize;
  end
  initial
  begin
    #100000;
    err_count++;
    summarize;
  end
endmodule // tb_stepper_motion_fault_supervisor
`default_nettype wire
